/* src/cad_pkg.sv */
// constants for the compare / adjust / divide execution slice
// assumes a single core clock and a decoder that hands over fetched operands
package cad_pkg;
  // opcodes
  localparam logic [7:0] OP_CP_RR  = 8'ha2;
  localparam logic [7:0] OP_CP_LO  = 8'ha3;
  localparam logic [7:0] OP_CP_HI  = 8'ha6;
  localparam logic [7:0] OP_CIBE   = 8'hc2;
  localparam logic [7:0] OP_CIBU   = 8'hd2;
  localparam logic [7:0] OP_BCD_R  = 8'h40;
  localparam logic [7:0] OP_BCD_IR = 8'h41;
  localparam logic [7:0] OP_DEC_R  = 8'h00;
  localparam logic [7:0] OP_DEC_IR = 8'h01;
  localparam logic [7:0] OP_WORD_SUBTRACT_ONE_R = 8'h80;
  localparam logic [7:0] OP_WORD_SUBTRACT_ONE_I = 8'h81;
  localparam logic [7:0] OP_IGOFF  = 8'h8f;
  localparam logic [7:0] OP_IGON   = 8'h9f;
  localparam logic [7:0] OP_DIV_LO = 8'h94;
  localparam logic [7:0] OP_DIV_HI = 8'h96;
  localparam logic [3:0] OP_CDB_LO = 4'ha;   // low nibble of count_down_branch
  // condition flag positions
  localparam int FL_C = 7;
  localparam int FL_Z = 6;
  localparam int FL_S = 5;
  localparam int FL_V = 4;
  localparam int FL_D = 3;
  localparam int FL_H = 2;
  // system_mode_reg global enable bit and its reset value
  localparam int         SYM_IEN     = 0;
  localparam logic       SYM_IEN_RST = 1'b0;
  // execution times in core cycles
  localparam logic [4:0] CYC_CP_R   = 5'h04;
  localparam logic [4:0] CYC_CP_M   = 5'h06;
  localparam logic [4:0] CYC_CIB_T  = 5'h12;  // 18, branch taken
  localparam logic [4:0] CYC_CIB_N  = 5'h10;  // 16, not taken
  localparam logic [4:0] CYC_SHORT  = 5'h04;  // adjust, subtract_one, interrupt on/off
  localparam logic [4:0] CYC_WORD   = 5'h08;
  localparam logic [4:0] CYC_DIV    = 5'h1a;  // 26
  localparam logic [4:0] CYC_DIV_Z  = 5'h0a;  // 10, divisor zero
  localparam logic [4:0] CYC_CDB    = 5'h08;
  // bcd adjust constants
  localparam logic [7:0] BCD_LO_ADD = 8'h06;
  localparam logic [7:0] BCD_HI_ADD = 8'h60;
  localparam logic [7:0] BCD_LO_SUB = 8'hfa;
  localparam logic [7:0] BCD_HI_SUB = 8'ha0;
  // one-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } cad_state_t;
endpackage

/* src/cad_divider.sv */
// iterative restoring divider, one quotient bit per clock
// assumes go_in only while idle and a non-zero divisor
module cad_divider #(
  parameter int DW = 8
) (
  input  wire logic            clock_in,
  input  wire logic            nrst_in,
  input  wire logic            go_in,
  input  wire logic [2*DW-1:0] dividend_in,
  input  wire logic [DW-1:0]   divisor_in,
  output logic      [DW-1:0]   quot_out,
  output logic      [DW-1:0]   rem_out,
  output logic                 done_out
);
  if (DW < 2 || DW > 16) begin : g_chk
    $error("cad_divider: DW out of range");
  end
  typedef struct packed {
    logic [2*DW-1:0] q;
    logic [DW:0]     r;
    logic [DW-1:0]   d;
    logic [5:0]      n;
    logic            busy;
    logic            done;
  } cad_div_t;
  cad_div_t st_q, st_d;
  logic [DW:0] trial;
  // shift in one dividend bit, keep the difference when it fits
  always_comb begin
    st_d  = st_q;
    trial = {st_q.r[DW-1:0], st_q.q[2*DW-1]};
    st_d.done = 1'b0;
    if (go_in) begin
      st_d.q    = dividend_in;
      st_d.r    = '0;
      st_d.d    = divisor_in;
      st_d.n    = 6'(2 * DW);
      st_d.busy = 1'b1;
    end else if (st_q.busy) begin
      st_d.q = {st_q.q[2*DW-2:0], 1'b0};
      if (trial >= {1'b0, st_q.d}) begin
        st_d.r    = trial - {1'b0, st_q.d};
        st_d.q[0] = 1'b1;
      end else begin
        st_d.r = trial;
      end
      st_d.n = st_q.n - 6'h01;
      if (st_q.n == 6'h01) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign quot_out = st_q.q[DW-1:0];
  assign rem_out  = st_q.r[DW-1:0];
  assign done_out = st_q.done;
endmodule

/* src/cad_exec.sv */
// execution slice: compare, compare-increment-branch, bcd adjust, decrements,
// interrupt global on/off, unsigned divide and count-down branch
// assumes the decoder presents fetched operands with a one-cycle start_in
// Overview of operation
// - compare subtracts source from destination, keeps operands, sets carry, zero, sign and overflow
// - compare_inc_branch_equal branches by offset when difference is zero
// - compare_inc_branch_unequal branches by offset when difference is non-zero
// - both compare-increment-branch forms bump the source pointer, flags untouched
// - compare-increment-branch takes 18 cycles taken, 16 not taken
// - bcd adjust after addition adds 00, 06, 60 or 66 and sets carry
// - bcd adjust after subtraction adds 00, FA, A0 or 9A, carry per case
// - bcd adjust of non-bcd operands may give any value
// - bcd adjust sets carry, zero, sign; keeps decimal and half-carry
// - subtract_one decrements a byte, updates zero, sign, overflow only
// - word_subtract_one decrements a 16-bit pair, updates zero, sign, overflow
// - interrupt_global_off clears system mode bit 0, flags untouched
// - with interrupts off, requests still pend but no vectoring happens
// - divide 16 by 8 bits: quotient to lower byte, remainder to upper
// - divide sets zero on zero divisor or quotient, sign from quotient bit 7
// - divide overflow on big quotient or zero divisor; carry if it overflows with a quotient below 2^9
// - divide takes 10 cycles with zero divisor, otherwise 26
// - count_down_branch decrements, branches on non-zero result, flags untouched
// - count_down_branch offset is added to address after the instruction
module cad_exec #(
  parameter int IRQ_N = 8
) (
  input  wire logic             clock_in,
  input  wire logic             nrst_in,
  input  wire logic             start_in,
  input  wire logic [7:0]       opcode_in,
  input  wire logic [7:0]       dst_in,
  input  wire logic [7:0]       src_in,
  input  wire logic [15:0]      dstw_in,
  input  wire logic [7:0]       ptr_in,
  input  wire logic [7:0]       rel_in,
  input  wire logic [15:0]      pc_next_in,
  input  wire logic [7:0]       flags_in,
  input  wire logic [IRQ_N-1:0] irq_req_in,
  input  wire logic [IRQ_N-1:0] pend_clr_in,
  input  wire logic [IRQ_N-1:0] irq_mask_in,
  output logic                  ready_out,
  output logic                  done_out,
  output logic                  res_wr_out,
  output logic                  res_word_out,
  output logic      [15:0]      res_data_out,
  output logic                  ptr_wr_out,
  output logic      [7:0]       ptr_data_out,
  output logic      [7:0]       flags_out,
  output logic                  pc_load_out,
  output logic      [15:0]      pc_out,
  output logic                  int_en_out,
  output logic      [IRQ_N-1:0] pend_out,
  output logic                  vector_req_out
);
  import cad_pkg::*;
  if (IRQ_N < 1 || IRQ_N > 32) begin : g_chk
    $error("cad_exec: IRQ_N out of range");
  end

  typedef struct packed {
    cad_state_t       state;
    logic [4:0]       cnt;
    logic [7:0]       op;
    logic             is_div;
    logic             div_zero;
    logic [15:0]      res;
    logic             wr;
    logic             word;
    logic [7:0]       ptr;
    logic             pwr;
    logic [7:0]       flags;
    logic             pcl;
    logic [15:0]      pc;
    logic             ien;
    logic [IRQ_N-1:0] pend;
  } cad_st_t;
  cad_st_t st_q, st_d;

  // decode of the instruction at the start strobe
  logic is_cp, is_cib, is_bcd, is_dec, is_word_subtract_one, is_div, is_cdb;
  assign is_cp   = (opcode_in >= OP_CP_RR) && (opcode_in <= OP_CP_HI);
  assign is_cib  = (opcode_in == OP_CIBE) || (opcode_in == OP_CIBU);
  assign is_bcd  = (opcode_in == OP_BCD_R) || (opcode_in == OP_BCD_IR);
  assign is_dec  = (opcode_in == OP_DEC_R) || (opcode_in == OP_DEC_IR);
  assign is_word_subtract_one = (opcode_in == OP_WORD_SUBTRACT_ONE_R) || (opcode_in == OP_WORD_SUBTRACT_ONE_I);
  assign is_div  = (opcode_in >= OP_DIV_LO) && (opcode_in <= OP_DIV_HI);
  assign is_cdb  = (opcode_in[3:0] == OP_CDB_LO);

  // shared arithmetic on the presented operands
  logic [8:0]  diff;
  logic [7:0]  dec8;
  logic [15:0] dec16;
  logic [15:0] rel_pc;
  logic        cib_take;
  assign diff   = {1'b0, dst_in} - {1'b0, src_in};
  assign dec8   = dst_in - 8'h01;
  assign dec16  = dstw_in - 16'h0001;
  assign rel_pc = pc_next_in + {{8{rel_in[7]}}, rel_in};
  assign cib_take = (opcode_in == OP_CIBE) ? (diff[7:0] == 8'h00)
                                           : (diff[7:0] != 8'h00);

  // bcd correction; operands not from a bcd add/sub give a don't-care result
  logic [3:0] nib_hi, nib_lo;
  logic       lo_fix, hi_fix;
  logic [7:0] bcd_add;
  logic [8:0] bcd_sum;
  assign nib_hi = dst_in[7:4];
  assign nib_lo = dst_in[3:0];
  assign lo_fix = flags_in[FL_H] || (nib_lo > 4'h9);
  assign hi_fix = flags_in[FL_C] || (nib_hi > 4'h9) || ((nib_hi == 4'h9) && (nib_lo > 4'h9));
  always_comb begin
    if (flags_in[FL_D]) begin
      bcd_add = (flags_in[FL_C] ? BCD_HI_SUB : 8'h00)
              + (flags_in[FL_H] ? BCD_LO_SUB : 8'h00);
    end else begin
      bcd_add = (hi_fix ? BCD_HI_ADD : 8'h00)
              + (lo_fix ? BCD_LO_ADD : 8'h00);
    end
  end
  assign bcd_sum = {1'b0, dst_in} + {1'b0, bcd_add};

  // divide overflow is judged up front from the dividend's upper byte
  logic        div_ovf, div_c, div_qz;
  logic [7:0]  dq, dr;
  logic        div_done;
  assign div_ovf = (dstw_in[15:8] >= src_in);
  assign div_c   = div_ovf && ({1'b0, dstw_in} < {src_in, 9'h000});
  assign div_qz  = (dstw_in < {8'h00, src_in});

  cad_divider #(
    .DW (8)
  ) u_div (
    .clock_in    (clock_in),
    .nrst_in     (nrst_in),
    .go_in       (start_in && ready_out && is_div && (src_in != 8'h00)),
    .dividend_in (dstw_in),
    .divisor_in  (src_in),
    .quot_out    (dq),
    .rem_out     (dr),
    .done_out    (div_done)
  );

  // sequencer: results are prepared at start, divide's when the divider finishes; all released after the cycle count
  always_comb begin
    st_d = st_q;
    // pending bits: a request in the clear cycle wins
    st_d.pend = (st_q.pend & ~pend_clr_in) | irq_req_in;
    case (st_q.state)
      ST_IDLE: begin
        if (start_in) begin
          st_d.state    = ST_RUN;
          st_d.op       = opcode_in;
          st_d.is_div   = 1'b0;
          st_d.div_zero = 1'b0;
          st_d.wr       = 1'b0;
          st_d.word     = 1'b0;
          st_d.pwr      = 1'b0;
          st_d.pcl      = 1'b0;
          st_d.flags    = flags_in;
          st_d.res      = {8'h00, dst_in};
          st_d.ptr      = ptr_in;
          st_d.pc       = pc_next_in;
          st_d.cnt      = CYC_SHORT - 5'h02;
          if (is_cp) begin
            st_d.flags[FL_C] = diff[8];
            st_d.flags[FL_Z] = (diff[7:0] == 8'h00);
            st_d.flags[FL_S] = diff[7];
            st_d.flags[FL_V] = (dst_in[7] != src_in[7]) && (diff[7] != dst_in[7]);
            st_d.cnt = ((opcode_in == OP_CP_RR) ? CYC_CP_R : CYC_CP_M) - 5'h02;
          end else if (is_cib) begin
            st_d.ptr = ptr_in + 8'h01;
            st_d.pwr = 1'b1;
            st_d.pcl = cib_take;
            st_d.pc  = cib_take ? rel_pc : pc_next_in;
            st_d.cnt = (cib_take ? CYC_CIB_T : CYC_CIB_N) - 5'h02;
          end else if (is_bcd) begin
            st_d.res         = {8'h00, bcd_sum[7:0]};
            st_d.wr          = 1'b1;
            st_d.flags[FL_C] = flags_in[FL_D] ? flags_in[FL_C] : hi_fix;
            st_d.flags[FL_Z] = (bcd_sum[7:0] == 8'h00);
            st_d.flags[FL_S] = bcd_sum[7];
          end else if (is_dec) begin
            st_d.res         = {8'h00, dec8};
            st_d.wr          = 1'b1;
            st_d.flags[FL_Z] = (dec8 == 8'h00);
            st_d.flags[FL_S] = dec8[7];
            st_d.flags[FL_V] = (dst_in == 8'h80);
          end else if (is_word_subtract_one) begin
            st_d.res         = dec16;
            st_d.wr          = 1'b1;
            st_d.word        = 1'b1;
            st_d.flags[FL_Z] = (dec16 == 16'h0000);
            st_d.flags[FL_S] = dec16[15];
            st_d.flags[FL_V] = (dstw_in == 16'h8000);
            st_d.cnt         = CYC_WORD - 5'h02;
          end else if (opcode_in == OP_IGOFF) begin
            st_d.ien = 1'b0;
          end else if (opcode_in == OP_IGON) begin
            st_d.ien = 1'b1;
          end else if (is_div) begin
            st_d.is_div      = 1'b1;
            st_d.div_zero    = (src_in == 8'h00);
            st_d.wr          = (src_in != 8'h00);
            st_d.word        = 1'b1;
            st_d.flags[FL_V] = div_ovf || (src_in == 8'h00);
            st_d.flags[FL_C] = (src_in != 8'h00) && div_c;
            st_d.flags[FL_Z] = (src_in == 8'h00) || div_qz;
            st_d.cnt = ((src_in == 8'h00) ? CYC_DIV_Z : CYC_DIV) - 5'h02;
          end else if (is_cdb) begin
            st_d.res = {8'h00, dec8};
            st_d.wr  = 1'b1;
            st_d.pcl = (dec8 != 8'h00);
            st_d.pc  = (dec8 != 8'h00) ? rel_pc : pc_next_in;
            st_d.cnt = CYC_CDB - 5'h02;
          end
        end
      end
      ST_RUN: begin
        // divider finishes well inside the 26-cycle window
        if (st_q.is_div && div_done) begin
          st_d.res         = {dr, dq};
          st_d.flags[FL_S] = dq[7];
        end
        if (st_q.cnt == 5'h00) begin
          st_d.state = ST_DONE;
        end else begin
          st_d.cnt = st_q.cnt - 5'h01;
        end
      end
      ST_DONE: begin
        st_d.state = ST_IDLE;
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      st_q       <= '0;
      st_q.state <= ST_IDLE;
      st_q.ien   <= SYM_IEN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs; write strobes only qualify in the done cycle
  assign ready_out      = (st_q.state == ST_IDLE);
  assign done_out       = (st_q.state == ST_DONE);
  assign res_wr_out     = done_out && st_q.wr;
  assign res_word_out   = st_q.word;
  assign res_data_out   = st_q.res;
  assign ptr_wr_out     = done_out && st_q.pwr;
  assign ptr_data_out   = st_q.ptr;
  assign flags_out      = st_q.flags;
  assign pc_load_out    = done_out && st_q.pcl;
  assign pc_out         = st_q.pc;
  assign int_en_out     = st_q.ien;
  assign pend_out       = st_q.pend;
  assign vector_req_out = st_q.ien && |(st_q.pend & irq_mask_in);

  a_cp_no_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_cp && diff[8]) |-> ##3 (!res_wr_out && flags_out[FL_C]))
    else $error("compare wrote its operand or lost borrow");
  a_cib_taken: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_cib && cib_take) |-> ##18 (done_out && pc_load_out))
    else $error("taken compare branch not done at 18");
  a_cib_not: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_cib && !cib_take) |-> ##16 (done_out && !pc_load_out))
    else $error("untaken compare branch not done at 16");
  a_cib_ptr_inc: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_cib) |=> (ptr_data_out == $past(ptr_in) + 8'h01))
    else $error("compare branch pointer not bumped");
  a_cib_ptr_wr: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (done_out && (st_q.op == OP_CIBE || st_q.op == OP_CIBU)) |-> (ptr_wr_out && !res_wr_out))
    else $error("compare branch pointer not written");
  a_div_zero_time: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_div && src_in == 8'h00)
      |-> ##10 (done_out && flags_out[FL_V] && flags_out[FL_Z] && !res_wr_out))
    else $error("divide by zero not 10 cycles");
  a_div_full_time: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_div && src_in != 8'h00) |-> ##26 (done_out && res_wr_out))
    else $error("divide not done at 26");
  a_div_result: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_div && src_in != 8'h00 && !div_ovf)
      |-> ##26 (res_data_out[7:0] * $past(src_in, 26) + res_data_out[15:8]
                == $past(dstw_in, 26)))
    else $error("quotient and remainder inconsistent");
  a_dec_flags: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_dec)
      |-> ##4 (done_out && res_data_out[7:0] == $past(dst_in, 4) - 8'h01
               && flags_out[FL_C] == $past(flags_in[FL_C], 4)))
    else $error("subtract_one result or carry wrong");
  a_igoff_clears: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && opcode_in == OP_IGOFF) |=> (!int_en_out && !vector_req_out))
    else $error("interrupts still enabled after global off");
  a_pend_keeps: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (irq_req_in != '0) |=> ((pend_out & $past(irq_req_in)) == $past(irq_req_in)))
    else $error("request lost its pending bit");
  a_cdb_branch: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_cdb && dec8 != 8'h00 && !is_cp && !is_cib)
      |-> ##8 (pc_load_out && flags_out == $past(flags_in, 8)))
    else $error("count-down branch missing or touched flags");

  // flags and timing the bench only sees in the done cycle
  a_cp_borrow_zero: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_cp) |=> (flags_out[FL_C] == ($past(src_in) > $past(dst_in))
      && flags_out[FL_Z] == ($past(src_in) == $past(dst_in))))
    else $error("compare borrow or zero flag wrong");
  a_cp_short_time: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && opcode_in == OP_CP_RR) |-> ##4 (done_out && !res_wr_out))
    else $error("register compare not done at 4 or wrote back");
  a_cib_flags_kept: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_cib) |=> (flags_out == $past(flags_in)))
    else $error("compare branch touched the flags");
  a_bcd_dh_kept: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_bcd) |=> (flags_out[FL_D] == $past(flags_in[FL_D])
      && flags_out[FL_H] == $past(flags_in[FL_H])
      && flags_out[FL_Z] == (res_data_out[7:0] == 8'h00)))
    else $error("adjust changed decimal or half-carry, or zero wrong");
  a_word_subtract_one_time: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_word_subtract_one) |-> ##8 (done_out && res_wr_out && res_word_out
      && flags_out[FL_C] == $past(flags_in[FL_C], 8)))
    else $error("word decrement not done at 8 or carry lost");
  a_igoff_time: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && opcode_in == OP_IGOFF)
      |-> ##4 (done_out && !res_wr_out && flags_out == $past(flags_in, 4)))
    else $error("global off not done at 4 or touched flags");
  a_div_dh_kept: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_div) |=> (flags_out[FL_D] == $past(flags_in[FL_D])
      && flags_out[FL_H] == $past(flags_in[FL_H])))
    else $error("divide changed decimal or half-carry");
  a_div_sign: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_div && src_in != 8'h00)
      |-> ##26 (flags_out[FL_S] == res_data_out[7]))
    else $error("divide sign not from quotient bit 7");
  a_cdb_no_branch: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_cdb && dec8 == 8'h00)
      |-> ##8 (done_out && res_wr_out && !pc_load_out))
    else $error("count-down branch taken on zero count");
  a_cdb_target: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (start_in && ready_out && is_cdb && dec8 != 8'h00)
      |=> (pc_out == $past(pc_next_in) + {{8{$past(rel_in[7])}}, $past(rel_in)}))
    else $error("count-down branch target not from next address");
endmodule

/* verification/cad_exec_tb.sv */
// self-checking bench for the compare / adjust / divide execution slice
// assumes cad_exec with default IRQ_N; outputs sampled on the falling edge
module cad_exec_tb import cad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, nrst_in, start_in;
  logic [7:0]  opcode_in, dst_in, src_in, ptr_in, rel_in, flags_in;
  logic [15:0] dstw_in, pc_next_in;
  logic [7:0]  irq_req_in, pend_clr_in, irq_mask_in;
  logic        ready_out, done_out, res_wr_out, res_word_out, ptr_wr_out, pc_load_out;
  logic        int_en_out, vector_req_out;
  logic [15:0] res_data_out, pc_out;
  logic [7:0]  ptr_data_out, flags_out, pend_out;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc;
  logic        c_wr, c_pw, c_pl, c_wd;
  logic [15:0] c_res, c_pc;
  logic [7:0]  c_fl, c_ptr;

  cad_exec dut (.clock_in(clock_in), .nrst_in(nrst_in), .start_in(start_in),
    .opcode_in(opcode_in), .dst_in(dst_in), .src_in(src_in), .dstw_in(dstw_in),
    .ptr_in(ptr_in), .rel_in(rel_in), .pc_next_in(pc_next_in), .flags_in(flags_in),
    .irq_req_in(irq_req_in), .pend_clr_in(pend_clr_in), .irq_mask_in(irq_mask_in),
    .ready_out(ready_out), .done_out(done_out), .res_wr_out(res_wr_out),
    .res_word_out(res_word_out), .res_data_out(res_data_out), .ptr_wr_out(ptr_wr_out),
    .ptr_data_out(ptr_data_out), .flags_out(flags_out), .pc_load_out(pc_load_out),
    .pc_out(pc_out), .int_en_out(int_en_out), .pend_out(pend_out),
    .vector_req_out(vector_req_out));

  // 250 MHz core clock
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one instruction: launch, count cycles to done, capture the results
  task automatic run(input logic [7:0] op, d, s, input logic [15:0] w,
                     input logic [7:0] p, r, input logic [15:0] pcn, input logic [7:0] f);
    int k;
    @(posedge clock_in);
    start_in <= 1'b1;
    opcode_in <= op;
    dst_in <= d;
    src_in <= s;
    dstw_in <= w;
    ptr_in <= p;
    rel_in <= r;
    pc_next_in <= pcn;
    flags_in <= f;
    @(posedge clock_in);
    start_in <= 1'b0;
    k = 0;
    cyc = 0;
    // bounded wait so a lost done cannot hang the run
    while (cyc == 0 && k < 40) begin
      @(negedge clock_in);
      k++;
      if (done_out === 1'b1) begin
        cyc = k;
        {c_wr, c_res, c_pw, c_ptr, c_fl, c_pl, c_pc} =
          {res_wr_out, res_data_out, ptr_wr_out, ptr_data_out, flags_out, pc_load_out, pc_out};
        c_wd = res_word_out;
      end
    end
    @(negedge clock_in);
    chk({14'h0000, done_out, ready_out}, 16'h0001);
  endtask

  task t_compare;
    run(OP_CP_RR, 8'h02, 8'h03, 16'h0000, 8'h00, 8'h00, 16'h0000, 8'h0c);
    chk({8'h00, c_fl}, 16'h00ac);
    chk({15'h0000, c_wr}, 16'h0000);
    run(OP_CP_HI, 8'h05, 8'h05, 16'h0000, 8'h00, 8'h00, 16'h0000, 8'h80);
    chk({7'h00, c_wr, c_fl}, 16'h0040);
  endtask

  task t_cib;
    run(OP_CIBE, 8'h02, 8'h02, 16'h0000, 8'h03, 8'h10, 16'h1000, 8'h5c);
    chk(cyc[15:0], 16'h0012);
    chk({7'h00, c_pl, c_pc[7:0]}, 16'h0110);
    chk({7'h00, c_pw, c_ptr}, 16'h0104);
    chk({8'h00, c_fl}, 16'h005c);
    chk(c_pc, 16'h1010);
    run(OP_CIBE, 8'h02, 8'h04, 16'h0000, 8'hff, 8'h10, 16'h1000, 8'hf0);
    chk(cyc[15:0], 16'h0010);
    chk({6'h00, c_pl, c_pw, c_ptr}, 16'h0100);
    chk({8'h00, c_fl}, 16'h00f0);
    run(OP_CIBU, 8'h02, 8'h04, 16'h0000, 8'h03, 8'h80, 16'h1000, 8'h00);
    chk(cyc[15:0], 16'h0012);
    chk(c_pc, 16'h0f80);
    chk({6'h00, c_pl, c_pw, c_ptr}, 16'h0304);
    run(OP_CIBU, 8'h07, 8'h07, 16'h0000, 8'h20, 8'h05, 16'h2000, 8'h00);
    chk(cyc[15:0], 16'h0010);
    chk({6'h00, c_pl, c_pw, c_ptr}, 16'h0121);
  endtask

  // byte result and flags; overflow is undefined for the adjust, so masked
  task bcd1(input logic [7:0] op, d, f, er, ef);
    run(op, d, 8'h00, 16'h0000, 8'h00, 8'h00, 16'h0000, f);
    chk({7'h00, c_wr, c_res[7:0]}, {8'h01, er});
    chk({8'h00, c_fl & 8'hef}, {8'h00, ef});
  endtask

  task t_bcd;
    bcd1(OP_BCD_R, 8'h3c, 8'h00, 8'h42, 8'h00);
    bcd1(OP_BCD_IR, 8'h9a, 8'h00, 8'h00, 8'hc0);
    bcd1(OP_BCD_R, 8'h25, 8'h80, 8'h85, 8'ha0);
    bcd1(OP_BCD_R, 8'h31, 8'h04, 8'h37, 8'h04);
    bcd1(OP_BCD_R, 8'ha5, 8'h00, 8'h05, 8'h80);
    bcd1(OP_BCD_R, 8'h31, 8'h08, 8'h31, 8'h08);
    bcd1(OP_BCD_IR, 8'h3f, 8'h0c, 8'h39, 8'h0c);
    bcd1(OP_BCD_R, 8'h85, 8'h88, 8'h25, 8'h88);
    bcd1(OP_BCD_R, 8'h9b, 8'h8c, 8'h35, 8'h8c);
  endtask

  // decrements: byte in the low half, words whole; carry must survive
  task dec1(input logic [7:0] op, input logic [15:0] w, input logic [7:0] f,
            input logic [15:0] er, input logic [7:0] ef, input logic [15:0] ec);
    run(op, w[7:0], 8'h00, w, 8'h00, 8'h00, 16'h0000, f);
    chk(op[7] ? c_res : {8'h00, c_res[7:0]}, er);
    chk({6'h00, c_wd, c_wr, c_fl}, {6'h00, op[7], 1'b1, ef});
    chk(cyc[15:0], ec);
  endtask

  task t_dec;
    dec1(OP_DEC_R, 16'h0003, 8'h8c, 16'h0002, 8'h8c, 16'h0004);
    dec1(OP_DEC_IR, 16'h0080, 8'h0c, 16'h007f, 8'h1c, 16'h0004);
    dec1(OP_DEC_R, 16'h0001, 8'h80, 16'h0000, 8'hc0, 16'h0004);
    dec1(OP_WORD_SUBTRACT_ONE_R, 16'h1234, 8'h0c, 16'h1233, 8'h0c, 16'h0008);
    dec1(OP_WORD_SUBTRACT_ONE_I, 16'h0001, 8'h80, 16'h0000, 8'hc0, 16'h0008);
    dec1(OP_WORD_SUBTRACT_ONE_R, 16'h8000, 8'h00, 16'h7fff, 8'h10, 16'h0008);
    dec1(OP_WORD_SUBTRACT_ONE_I, 16'h0000, 8'h00, 16'hffff, 8'h20, 16'h0008);
  endtask

  task div1(input logic [7:0] op, s, f, input logic [15:0] w, er,
            input logic [7:0] ef, input logic [15:0] ec);
    run(op, 8'h00, s, w, 8'h00, 8'h00, 16'h0000, f);
    chk(cyc[15:0], ec);
    chk({8'h00, c_fl}, {8'h00, ef});
    if (s != 8'h00) chk({15'h0000, c_wr} == 16'h0001 ? c_res : 16'hdead, er);
    else chk({15'h0000, c_wr}, 16'h0000);
  endtask

  task t_div;
    div1(OP_DIV_LO, 8'h40, 8'h0c, 16'h1003, 16'h0340, 8'h0c, 16'h001a);
    div1(OP_DIV_HI, 8'h05, 8'h00, 16'h0000, 16'h0000, 8'h40, 16'h001a);
    div1(8'h95, 8'h10, 8'h0c, 16'h1800, 16'h0080, 8'hbc, 16'h001a);
    div1(OP_DIV_LO, 8'h01, 8'h00, 16'h01ff, 16'h00ff, 8'hb0, 16'h001a);
    div1(OP_DIV_LO, 8'h01, 8'h00, 16'h0200, 16'h0000, 8'h10, 16'h001a);
    div1(OP_DIV_HI, 8'h00, 8'h2c, 16'h1234, 16'h0000, 8'h7c, 16'h000a);
  endtask

  task t_cdb;
    // counter register sits in the working bank; its addressing is outside the slice
    run(8'h1a, 8'h02, 8'h00, 16'h0000, 8'h00, 8'hf0, 16'h1000, 8'h5c);
    chk(c_pc, 16'h0ff0);
    chk({c_pl, c_wr, c_fl, c_res[5:0]}, {2'h3, 8'h5c, 6'h01});
    chk(cyc[15:0], 16'h0008);
    run(8'h3a, 8'h01, 8'h00, 16'h0000, 8'h00, 8'h7f, 16'h1000, 8'ha0);
    chk({c_pl, c_wr, c_fl, c_res[5:0]}, {2'h1, 8'ha0, 6'h00});
  endtask

  // mask is set while global servicing is off; requests are raised with it both on and off
  task t_irq;
    @(posedge clock_in);
    irq_mask_in <= 8'h03;
    run(OP_IGON, 8'h00, 8'h00, 16'h0000, 8'h00, 8'h00, 16'h0000, 8'h00);
    @(posedge clock_in);
    irq_req_in <= 8'h01;
    @(posedge clock_in);
    irq_req_in <= 8'h00;
    @(negedge clock_in);
    chk({6'h00, int_en_out, vector_req_out, pend_out}, 16'h0301);
    run(OP_IGOFF, 8'h00, 8'h00, 16'h0000, 8'h00, 8'h00, 16'h0000, 8'hd4);
    chk({7'h00, int_en_out, c_fl}, 16'h00d4);
    chk(cyc[15:0], 16'h0004);
    chk({6'h00, int_en_out, vector_req_out, pend_out}, 16'h0001);
    @(posedge clock_in);
    pend_clr_in <= 8'h01;
    @(posedge clock_in);
    pend_clr_in <= 8'h00;
    irq_req_in <= 8'h02;
    @(posedge clock_in);
    irq_req_in <= 8'h00;
    @(negedge clock_in);
    chk({6'h00, int_en_out, vector_req_out, pend_out}, 16'h0002);
    // a request in the clear cycle keeps its pending bit
    @(posedge clock_in);
    pend_clr_in <= 8'h02;
    irq_req_in <= 8'h02;
    @(posedge clock_in);
    pend_clr_in <= 8'h00;
    irq_req_in <= 8'h00;
    @(negedge clock_in);
    chk({6'h00, int_en_out, vector_req_out, pend_out}, 16'h0002);
  endtask

  // watchdog well beyond the roughly 400 cycles the tests need
  initial begin
    repeat (5000) @(posedge clock_in);
    miscompares++;
    report_and_stop;
  end

  // main sequence
  initial begin
    {nrst_in, start_in, opcode_in, dst_in, src_in, ptr_in, rel_in, flags_in} = '0;
    {dstw_in, pc_next_in, irq_req_in, pend_clr_in, irq_mask_in} = '0;
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(negedge clock_in);
    chk({6'h00, ready_out, int_en_out, pend_out}, 16'h0200);
    t_compare;
    t_cib;
    t_bcd;
    t_dec;
    t_div;
    t_cdb;
    t_irq;
    report_and_stop;
  end
endmodule
